/* rtl/ecpp_pkg.sv */
/*
  ecpp_pkg: register offsets, field positions, modes, reset values and carrier
  types for the extended-capabilities parallel port.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package ecpp_pkg;
  localparam logic [10:0] OFS_DATA   = 11'h000;
  localparam logic [10:0] OFS_STATUS = 11'h001;
  localparam logic [10:0] OFS_CTRL   = 11'h002;
  localparam logic [10:0] OFS_FIFO   = 11'h400;
  localparam logic [10:0] OFS_CFGB   = 11'h401;
  localparam logic [10:0] OFS_ECR    = 11'h402;

  localparam logic [7:0] CAP_ID_VAL     = 8'h10;
  localparam logic [2:0] STATUS_LOW_ONE = 3'h7;
  localparam logic [1:0] CTRL_HIGH_ONE  = 2'h3;
  localparam logic [5:0] CTRL_RST       = 6'h00;
  localparam logic [7:0] DATA_RST       = 8'h00;
  localparam logic [5:0] CFGB_RST       = 6'h00;
  localparam logic       COMPRESS_CAP   = 1'b0;

  localparam int CTRL_DIR_BIT = 5;
  localparam int CTRL_AIE_BIT = 4;
  localparam int CTRL_SLI_BIT = 3;
  localparam int CTRL_INI_BIT = 2;
  localparam int CTRL_AFD_BIT = 1;
  localparam int CTRL_STB_BIT = 0;
  localparam int ECR_MODE_LSB = 5;
  localparam int AFIFO_FLAG_BIT = 7;

  localparam int FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    ECPP_MODE_SPP  = 3'b000,
    ECPP_MODE_BIDI = 3'b001,
    ECPP_MODE_CFIF = 3'b010,
    ECPP_MODE_ECP  = 3'b011,
    ECPP_MODE_TEST = 3'b110,
    ECPP_MODE_CFG  = 3'b111
  } ecpp_mode_t;

  // one fifo entry: the byte plus its command tag
  typedef struct packed {
    logic       is_cmd;
    logic [7:0] data;
  } ecpp_entry_t;

  // peripheral-driven lines
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic reverse_ack_line;
    logic online_flag;
    logic fault_n;
  } ecpp_periph_t;
endpackage

/* rtl/ecpp_fifo.sv */
/*
  ecpp_fifo: flip-flop fifo with valid/ready on both sides and honest flags.
  assumes: single clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
module ecpp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,  // clock
  input  wire logic             resetn_i,   // async reset, low
  input  wire logic             flush_i,    // empty the fifo
  input  wire logic [WIDTH-1:0] wr_data_i,  // push data
  input  wire logic             wr_valid_i, // push request
  output logic                  wr_ready_o, // room available
  output logic [WIDTH-1:0]      rd_data_o,  // head entry
  output logic                  rd_valid_o, // head valid
  input  wire logic             rd_ready_i, // pop
  output logic                  full_o,     // full flag
  output logic                  empty_o     // empty flag
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = wr_valid_i && wr_ready_o;
  wire              pop  = rd_valid_o && rd_ready_i;

  assign full_o     = (count == (AW+1)'(DEPTH));
  assign empty_o    = (count == '0);
  assign wr_ready_o = !full_o;
  assign rd_valid_o = !empty_o;
  assign rd_data_o  = mem[rd_ptr];

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= AW'(wr_ptr + 1'b1);
      if (pop) rd_ptr <= AW'(rd_ptr + 1'b1);
      count <= (AW+1)'(count + push - pop);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) mem[wr_ptr] <= wr_data_i;
  end

  fifo_count_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    count <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
  fifo_full_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    full_o && !rd_ready_i && !flush_i |=> full_o) else $error("full dropped without pop");
endmodule

/* rtl/ecpp_port.sv */
/*
  ecpp_port: host-side extended-capabilities parallel port, register decode
  and forward/reverse handshake engine over one shared fifo.
  assumes: cpu bus signals are synchronous to sys_clk_i; rd_i/wr_i are one-cycle
  strobes; peripheral pins are asynchronous and are synchronised here.
*/
// Functional notes
// - forward byte strobed, interlocked with peripheral ack; code strobes in mode 011 only, in 010 the strobe follows control bit 0
// - data drivers on only when link forward
// - host ack requests a reverse byte
// - host ack high data, low command forward
// - fault asserted forward raises error event
// - reverse request low selects reverse direction
// - active-mode output held deasserted in ecp
// - offset 000h data or address fifo
// - offsets 001h, 002h status and control
// - offset 400h fifo view or config A
// - 401h config B in 111; 402h ecr
// - base address added, qualified by dma enable
// - config A reads fixed 10h
// - status bit layout, low bits read one
// - control bit layout, top bits read one
// - address fifo bit 7 flags address/count
// - config B field layout
// - ecr field order mode..empty
// - ecr mode bits 7:5 read/write
// - all fifo views share one storage
`timescale 1ns/1ps
module ecpp_port
  import ecpp_pkg::*;
#(
  parameter logic [15:0] BASE_ADDR = 16'h0378
) (
  input  wire logic                   sys_clk_i,         // 100 MHz clock
  input  wire logic                   resetn_i,          // async reset, low
  input  wire logic [15:0]            addr_i,            // cpu address
  input  wire logic                   dma_addr_enable_i, // dma owns address bus
  input  wire logic                   rd_i,              // read strobe
  input  wire logic                   wr_i,              // write strobe
  input  wire logic [7:0]             wdata_i,           // write data
  output logic [7:0]                  rdata_o,           // read data
  input  wire logic                   irq_line_i,        // live irq line level
  input  wire ecpp_pkg::ecpp_periph_t periph_i,          // peripheral inputs
  input  wire logic [7:0]             port_data_line_i,  // data pins in
  output logic [7:0]                  port_data_line_o,  // data pins out
  output logic                        port_data_oe_o,    // data drive enable
  output logic                        host_strobe_n_o,   // host clock
  output logic                        host_handshake_n_o,// host ack
  output logic                        init_n_o,          // reverse request
  output logic                        active_mode_n_o,   // 1284 active
  output logic                        port_direction_o,  // direction indicator
  output logic                        error_event_o,     // error pulse
  output logic                        ack_rise_o         // ack rising pulse
);
  // two-flop synchronisers for the peripheral lines and data
  ecpp_periph_t p_s1, p_s2;
  logic [7:0]   d_s1, d_s2;
  // idle levels for the active-low lines, so reset is not followed by a false ack or fault edge
  localparam ecpp_periph_t P_IDLE = '{busy: 1'b0, ack_n: 1'b1, reverse_ack_line: 1'b0,
                                      online_flag: 1'b0, fault_n: 1'b1};
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      p_s1 <= P_IDLE;
      p_s2 <= P_IDLE;
      d_s1 <= '0;
      d_s2 <= '0;
    end else begin
      p_s1 <= periph_i;
      p_s2 <= p_s1;
      d_s1 <= port_data_line_i;
      d_s2 <= d_s1;
    end
  end

  // registers
  logic [7:0] parallel_data;
  logic [5:0] line_control;
  logic [5:0] irq_dma_config;
  logic [2:0] ecr_mode;
  logic       error_irq_enable_n;
  logic       dma_enable;
  logic       service_flag;
  logic       ack_q;
  logic       fault_q;

  wire [10:0] ofs = 11'(addr_i - BASE_ADDR);
  wire in_range   = (addr_i >= BASE_ADDR) && ((addr_i - BASE_ADDR) < 16'h0403);
  wire sel        = in_range && !dma_addr_enable_i;
  wire m_spp      = (ecr_mode == ECPP_MODE_SPP) || (ecr_mode == ECPP_MODE_BIDI);
  wire m_ecp      = (ecr_mode == ECPP_MODE_ECP);
  wire m_cfif     = (ecr_mode == ECPP_MODE_CFIF);
  wire m_test     = (ecr_mode == ECPP_MODE_TEST);
  wire m_cfg      = (ecr_mode == ECPP_MODE_CFG);

  wire sel_data   = sel && ofs == OFS_DATA && m_spp;
  wire sel_afifo  = sel && ofs == OFS_DATA && m_ecp;
  wire sel_status = sel && ofs == OFS_STATUS;
  wire sel_ctrl   = sel && ofs == OFS_CTRL;
  wire sel_dfifo  = sel && ofs == OFS_FIFO && (m_cfif || m_ecp || m_test);
  wire sel_capa   = sel && ofs == OFS_FIFO && m_cfg;
  wire sel_cfgb   = sel && ofs == OFS_CFGB && m_cfg;
  wire sel_ecr    = sel && ofs == OFS_ECR;

  // direction bit only acts outside modes 000 and 010
  wire dir_rev    = line_control[CTRL_DIR_BIT] && !(ecr_mode == ECPP_MODE_SPP) && !m_cfif;

  // shared fifo for all views
  ecpp_entry_t f_wdata, f_rdata;
  logic        f_wvalid, f_wready, f_rvalid, f_rready, f_full, f_empty;
  logic        eng_push, eng_pop;
  ecpp_entry_t eng_entry;
  wire cpu_push   = wr_i && (sel_afifo || sel_dfifo);
  wire cpu_pop    = rd_i && sel_dfifo && !f_empty;
  assign f_wvalid = cpu_push || eng_push;
  assign f_wdata  = cpu_push ? ecpp_entry_t'{is_cmd: sel_afifo, data: wdata_i} : eng_entry;
  assign f_rready = cpu_pop || eng_pop;

  ecpp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .flush_i    (wr_i && sel_ecr),
    .wr_data_i  (f_wdata),
    .wr_valid_i (f_wvalid),
    .wr_ready_o (f_wready),
    .rd_data_o  (f_rdata),
    .rd_valid_o (f_rvalid),
    .rd_ready_i (f_rready),
    .full_o     (f_full),
    .empty_o    (f_empty)
  );

  // read mux
  wire [7:0] status_val = {!p_s2.busy, p_s2.ack_n, p_s2.reverse_ack_line,
                           p_s2.online_flag, p_s2.fault_n, STATUS_LOW_ONE};
  wire [7:0] ctrl_val   = {CTRL_HIGH_ONE, line_control};
  wire [7:0] cfgb_val   = {COMPRESS_CAP, irq_line_i, irq_dma_config};
  wire [7:0] ecr_val    = {ecr_mode, error_irq_enable_n, dma_enable,
                           service_flag, f_full, f_empty};
  wire [7:0] data_val   = dir_rev ? d_s2 : parallel_data;
  // an empty test fifo re-reads its head slot rather than stalling
  wire [7:0] next_rdata = sel_data   ? data_val :
                          sel_status ? status_val :
                          sel_ctrl   ? ctrl_val :
                          sel_dfifo  ? f_rdata.data :
                          sel_capa   ? CAP_ID_VAL :
                          sel_cfgb   ? cfgb_val :
                          sel_ecr    ? ecr_val : 8'h00;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) rdata_o <= 8'h00;
    else if (rd_i) rdata_o <= next_rdata;
  end

  // register writes
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      parallel_data      <= DATA_RST;
      line_control       <= CTRL_RST;
      irq_dma_config     <= CFGB_RST;
      ecr_mode           <= ECPP_MODE_SPP;
      error_irq_enable_n <= 1'b1;
      dma_enable         <= 1'b0;
    end else if (wr_i) begin
      if (sel_data) parallel_data <= wdata_i;
      if (sel_ctrl) line_control <= wdata_i[5:0];
      if (sel_cfgb) irq_dma_config <= wdata_i[5:0];
      if (sel_ecr) begin
        ecr_mode           <= wdata_i[7:ECR_MODE_LSB];
        error_irq_enable_n <= wdata_i[4];
        dma_enable         <= wdata_i[3];
      end
    end
  end

  // handshake engine
  typedef enum logic [2:0] {
    ECPP_IDLE   = 3'b000,
    ECPP_FSTROBE= 3'b001,
    ECPP_FWAIT  = 3'b010,
    ECPP_RREQ   = 3'b011,
    ECPP_RWAIT  = 3'b100
  } ecpp_state_t;
  ecpp_state_t state, next_state;
  logic [7:0]  out_byte;
  logic        out_cmd;

  wire link_fwd   = p_s2.reverse_ack_line;
  wire eng_mode   = m_ecp || m_cfif;
  wire fwd_go     = eng_mode && !dir_rev && link_fwd && f_rvalid && !p_s2.busy;

  always_comb begin
    next_state = state;
    eng_pop    = 1'b0;
    eng_push   = 1'b0;
    eng_entry  = ecpp_entry_t'{is_cmd: !p_s2.busy, data: d_s2};
    case (state)
      ECPP_IDLE: begin
        if (fwd_go && !cpu_pop) begin
          eng_pop    = 1'b1;
          next_state = ECPP_FSTROBE;
        end else if (m_ecp && dir_rev && !link_fwd && f_wready && !cpu_push) begin
          next_state = ECPP_RREQ;
        end
      end
      ECPP_FSTROBE: if (p_s2.busy) next_state = ECPP_FWAIT;
      ECPP_FWAIT:   if (!p_s2.busy) next_state = ECPP_IDLE;
      ECPP_RREQ: begin
        if (!p_s2.ack_n && !cpu_push) begin
          eng_push   = 1'b1;
          next_state = ECPP_RWAIT;
        end else if (!dir_rev) begin
          // direction turned forward before the byte came: give up the request
          next_state = ECPP_IDLE;
        end
      end
      ECPP_RWAIT:   if (p_s2.ack_n) next_state = ECPP_IDLE;
      default:      next_state = ECPP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state    <= ECPP_IDLE;
      out_byte <= 8'h00;
      out_cmd  <= 1'b0;
    end else begin
      state <= next_state;
      if (eng_pop) begin
        out_byte <= f_rdata.data;
        out_cmd  <= f_rdata.is_cmd;
      end
    end
  end

  // pins
  wire ecp_active = m_ecp;
  assign port_data_line_o   = eng_mode ? out_byte : parallel_data;
  assign port_data_oe_o     = !dir_rev && link_fwd;
  assign host_strobe_n_o    = ecp_active ? !(state == ECPP_FSTROBE)
                                         : !line_control[CTRL_STB_BIT];
  assign host_handshake_n_o = ecp_active ? (dir_rev ? !(state == ECPP_RREQ)
                                                    : !out_cmd)
                                         : !line_control[CTRL_AFD_BIT];
  assign init_n_o           = ecp_active ? !dir_rev
                                         : line_control[CTRL_INI_BIT];
  assign active_mode_n_o    = ecp_active ? 1'b1
                                         : !line_control[CTRL_SLI_BIT];
  assign port_direction_o   = dir_rev;

  // events: fault only counts while forward; ack rising for the ack interrupt
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q        <= 1'b1;
      fault_q      <= 1'b1;
      service_flag <= 1'b0;
    end else begin
      ack_q        <= p_s2.ack_n;
      fault_q      <= p_s2.fault_n;
      service_flag <= dir_rev ? f_full : f_empty;
    end
  end
  assign error_event_o = fault_q && !p_s2.fault_n && link_fwd && !dir_rev;
  assign ack_rise_o    = !ack_q && p_s2.ack_n && line_control[CTRL_AIE_BIT];

  // assertions
  drive_fwd_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    port_data_oe_o |-> link_fwd && !dir_rev) else $error("data driven in reverse");
  active_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    m_ecp |-> active_mode_n_o) else $error("active asserted in ecp");
  strobe_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    state == ECPP_FSTROBE && !p_s2.busy |=> !host_strobe_n_o || !m_ecp)
    else $error("strobe released before peripheral ack");
  cmd_tag_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    eng_push |-> f_wdata.is_cmd == !p_s2.busy) else $error("reverse tag wrong");
  capa_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    rd_i && sel_capa |=> rdata_o == 8'h10) else $error("config A value wrong");
  status_low_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    rd_i && sel_status |=> rdata_o[2:0] == 3'b111) else $error("status low bits");
  dma_qual_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    dma_addr_enable_i && wr_i |=> $stable(ecr_mode)) else $error("dma cycle wrote ecr");
  ecr_mode_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr_i && sel_ecr |=> ecr_mode == $past(wdata_i[7:5])) else $error("mode not written");
  afifo_tag_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    cpu_push |-> f_wdata.is_cmd == sel_afifo) else $error("address fifo tag");
  flags_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !(f_full && f_empty)) else $error("full and empty together");
  fault_rev_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    dir_rev |-> !error_event_o) else $error("error event in reverse");
  hostack_fwd_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    m_ecp && !dir_rev |-> host_handshake_n_o == !out_cmd) else $error("host ack tag");

  fwd_byte_c: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    state == ECPP_FSTROBE ##[1:20] state == ECPP_IDLE);
  rev_byte_c: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) eng_push);
  full_c: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) f_full);
endmodule

/* dv/ecpp_periph_model.sv */
/*
  ecpp_periph_model: behavioural ecp peripheral on the far side of the port;
  takes forward bytes into a log and returns numbered bytes in reverse.
  assumes: host outputs sampled on sys_clk_i; ecp_i high only in mode 011.
*/
`timescale 1ns/1ps
module ecpp_periph_model (
  input  wire logic           sys_clk_i,   // clock
  input  wire logic           resetn_i,    // async reset, low
  input  wire logic           ecp_i,       // act as ecp peripheral
  input  wire logic           slow_i,      // answer late
  input  wire logic           fault_n_i,   // fault line level
  input  wire logic           strobe_n_i,  // host clock
  input  wire logic           hs_n_i,      // host ack
  input  wire logic           init_n_i,    // reverse request
  input  wire logic [7:0]     host_data_i, // host data out
  input  wire logic           host_oe_i,   // host drives data
  output logic [7:0]          line_o,      // resolved data lines
  output ecpp_pkg::ecpp_periph_t periph_o, // peripheral lines
  output logic [26:0]         log_o,       // last three forward entries
  output logic [7:0]          fcnt_o       // forward byte count
);
  import ecpp_pkg::*;
  logic       busy, ack_n, rack, drv;
  logic [7:0] rbyte, last, cnt;
  logic [2:0] wt;
  logic       go;
  assign go = !slow_i || (wt == 3'h0);
  // released lines show the inverse of their last level, never a stale byte
  assign line_o = host_oe_i ? host_data_i : (drv ? rbyte : ~last);
  assign periph_o = '{busy: busy, ack_n: ack_n, reverse_ack_line: rack,
                      online_flag: 1'b1, fault_n: fault_n_i};
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {busy, drv, wt, cnt, fcnt_o, log_o, rbyte, last} <= '0;
      {ack_n, rack} <= 2'b11;
    end else begin
      wt <= wt + 3'h1;
      last <= line_o;
      if (!ecp_i) begin
        {busy, drv} <= 2'b00;
        {ack_n, rack} <= 2'b11;
      end else if (!init_n_i) begin
        if (go && rack) begin
          rack <= 1'b0;
        end else if (go && !rack && !hs_n_i && ack_n && !drv) begin
          drv <= 1'b1;
          rbyte <= 8'hc0 + cnt;
          busy <= ~cnt[0];
        end else if (drv && ack_n && !hs_n_i) begin
          ack_n <= 1'b0;
        end else if (hs_n_i && !ack_n) begin
          {ack_n, drv} <= 2'b10;
          cnt <= cnt + 8'h1;
        end
      end else if (!rack) begin
        if (go) begin
          {rack, busy, drv, ack_n} <= 4'b1001;
        end
      end else if (go && !strobe_n_i && !busy) begin
        busy <= 1'b1;
        log_o <= {log_o[17:0], ~hs_n_i, line_o};
        fcnt_o <= fcnt_o + 8'h1;
      end else if (go && strobe_n_i && busy) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

/* dv/ecp_parallel_port_host_tb_top.sv */
/*
  ecp_parallel_port_host_tb_top: self-checking bench for ecpp_port with a
  peripheral model; register rows first, then fifo, link and reset tests.
  assumes: BASE_ADDR default; one-cycle rd/wr strobes as the port expects.
*/
`timescale 1ns/1ps
module ecp_parallel_port_host_tb_top;
  import ecpp_pkg::*;
  localparam logic [15:0] BASE = 16'h0378;
  logic        sys_clk_i = 1'b0, resetn_i = 1'b0;
  logic [15:0] addr = '0;
  logic        dma = 1'b0, rd = 1'b0, wr = 1'b0, irq = 1'b1, fault_n = 1'b1;
  logic        ecp = 1'b0, slow = 1'b0;
  logic [7:0]  wdata = '0, rdata, pd_o, line, fcnt, v;
  logic        oe, stb_n, hs_n, init_n, act_n, port_direction, err_ev, ack_rise;
  logic [26:0] log_w;
  ecpp_periph_t periph;
  int failures = 0, checked = 0, ev_cnt = 0, rs_cnt = 0, n, e0;
  logic [20:0] rows [16];

  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (err_ev === 1'b1) ev_cnt++;
  always @(posedge sys_clk_i) if (ack_rise === 1'b1) rs_cnt++;

  ecpp_port uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr),
    .dma_addr_enable_i(dma), .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata),
    .irq_line_i(irq), .periph_i(periph), .port_data_line_i(line),
    .port_data_line_o(pd_o), .port_data_oe_o(oe), .host_strobe_n_o(stb_n),
    .host_handshake_n_o(hs_n), .init_n_o(init_n), .active_mode_n_o(act_n),
    .port_direction_o(port_direction), .error_event_o(err_ev), .ack_rise_o(ack_rise));
  ecpp_periph_model prt (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ecp_i(ecp),
    .slow_i(slow), .fault_n_i(fault_n), .strobe_n_i(stb_n), .hs_n_i(hs_n),
    .init_n_i(init_n), .host_data_i(pd_o), .host_oe_i(oe), .line_o(line),
    .periph_o(periph), .log_o(log_w), .fcnt_o(fcnt));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [10:0] ofs, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= BASE + 16'(ofs);
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [10:0] ofs, input logic dm, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= BASE + 16'(ofs);
    dma <= dm;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    dma <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    complete_run();
  end

  initial begin
    // row: write flag, dma flag, offset, write data or expected read
    rows = '{{2'b10, 11'h402, 8'he0}, {2'b00, 11'h400, 8'h10}, {2'b10, 11'h401, 8'h2b},
             {2'b00, 11'h401, 8'h6b}, {2'b01, 11'h401, 8'h00}, {2'b00, 11'h402, 8'he5},
             {2'b00, 11'h001, 8'hff}, {2'b10, 11'h002, 8'h0f}, {2'b00, 11'h002, 8'hcf},
             {2'b10, 11'h402, 8'h00}, {2'b10, 11'h000, 8'h5a}, {2'b00, 11'h401, 8'h00},
             {2'b00, 11'h000, 8'h5a}, {2'b00, 11'h400, 8'h00}, {2'b00, 11'h003, 8'h00},
             {2'b10, 11'h002, 8'h04}};
    repeat (16) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][20]) reg_wr(rows[i][18:8], rows[i][7:0]);
      else begin
        reg_rd(rows[i][18:8], rows[i][19], v);
        chk(v, rows[i][7:0], "register row");
      end
    end
    dma <= 1'b1;
    reg_wr(11'h402, 8'h20);
    dma <= 1'b0;
    reg_rd(11'h402, 1'b0, v);
    chk(v, 8'h05, "dma write ignored");
    $display("test register rows done");
    // test mode: one extra push past depth must be refused
    reg_wr(11'h402, 8'hc0);
    for (int i = 0; i <= FIFO_DEPTH; i++) reg_wr(11'h400, 8'h40 + 8'(i));
    reg_rd(11'h402, 1'b0, v);
    chk(v[1:0], 2'b10, "fifo full flag");
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      reg_rd(11'h400, 1'b0, v);
      chk(v, 8'h40 + 8'(i), "fifo order");
    end
    reg_rd(11'h402, 1'b0, v);
    chk(v[1:0], 2'b01, "fifo empty flag");
    $display("test fifo done");
    reg_wr(11'h402, 8'h60);
    ecp <= 1'b1;
    slow <= 1'b1;
    reg_wr(11'h000, 8'h85);
    reg_wr(11'h400, 8'h33);
    reg_wr(11'h400, 8'h44);
    for (n = 0; n < 400 && fcnt !== 8'h03; n++) @(posedge sys_clk_i);
    chk(log_w, {1'b1, 8'h85, 1'b0, 8'h33, 1'b0, 8'h44}, "forward log");
    chk(act_n, 1'b1, "active output in ecp");
    chk(oe, 1'b1, "forward drive");
    e0 = ev_cnt;
    fault_n <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    chk(ev_cnt - e0, 1, "error event forward");
    fault_n <= 1'b1;
    $display("test forward done");
    slow <= 1'b0;
    reg_wr(11'h002, 8'h34);
    repeat (20) @(posedge sys_clk_i);
    chk({init_n, oe, port_direction}, 3'b001, "reverse direction");
    e0 = ev_cnt;
    fault_n <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    chk(ev_cnt - e0, 0, "no error event reverse");
    fault_n <= 1'b1;
    v = '0;
    for (n = 0; n < 100 && v[1] !== 1'b1; n++) reg_rd(11'h402, 1'b0, v);
    chk(v[1], 1'b1, "reverse fills fifo");
    for (int i = 0; i < 4; i++) begin
      reg_rd(11'h400, 1'b0, v);
      chk(v, 8'hc0 + 8'(i), "reverse byte");
    end
    chk(rs_cnt > 0, 1'b1, "ack rise event");
    reg_wr(11'h002, 8'h04);
    repeat (20) @(posedge sys_clk_i);
    chk({init_n, oe, port_direction}, 3'b110, "back to forward");
    $display("test reverse done");
    resetn_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk({stb_n, act_n}, 2'b11, "outputs in reset");
    resetn_i <= 1'b1;
    ecp <= 1'b0;
    reg_rd(11'h002, 1'b0, v);
    chk(v, 8'hc0, "control after reset");
    reg_rd(11'h402, 1'b0, v);
    chk(v, 8'h15, "ecr after reset");
    $display("test reset done");
    complete_run();
  end
endmodule
